//--- logic/usf_regs.svh
`ifndef USF_REGS_SVH
`define USF_REGS_SVH

// byte addresses of the register words
`define USF_STATUS_ADDR 32'h0000_44a4
`define USF_CTRL_ADDR 32'h0000_44c0

// status word field positions
`define USF_BIT_CTS 0
`define USF_BIT_RX_VALID 1
`define USF_BIT_TX_SPACE 2
`define USF_BIT_RX_OVERRUN 3
`define USF_BIT_RX_FRAMING 4
`define USF_BIT_RX_PARITY 5
`define USF_BIT_TX_IDLE 6
`define USF_STATUS_WIDTH 16

// status word reset value: only tx idle reads one
`define USF_STATUS_RESET 16'h0040

// control word fields and reset value
`define USF_BIT_FLOW_EN 0
`define USF_CTRL_RESET 1'h0

// sticky flag indices inside the flag array
`define USF_FLAG_PARITY 0
`define USF_FLAG_FRAMING 1
`define USF_FLAG_OVERRUN 2
`define USF_NUM_FLAGS 3

// axi response codes
`define USF_RESP_OKAY 2'h0
`define USF_RESP_SLVERR 2'h2
`define USF_RESP_DECERR 2'h3

`endif

//--- logic/usf_pkg.sv
package usf_pkg;

  // write channel sequencing; one bit changes per step except idle to resp and resp back to idle
  typedef enum logic [1:0] {
    USF_WR_IDLE = 2'h0,
    USF_WR_HAVE_AW = 2'h1,
    USF_WR_RESP = 2'h3,
    USF_WR_HAVE_W = 2'h2
  } usf_wr_state_e;

  // register selected by an address
  typedef enum logic [1:0] {
    USF_SEL_NONE = 2'h0,
    USF_SEL_STATUS = 2'h1,
    USF_SEL_CTRL = 2'h2
  } usf_sel_e;

  // state handed over by the rest of the serial unit
  typedef struct packed {
    logic tx_fifo_empty;
    logic tx_ser_idle;
    logic tx_fifo_room;
    logic rx_fifo_has_data;
    logic rx_char_push;
    logic rx_char_parity_err;
    logic rx_char_frame_err;
    logic rx_overrun_evt;
    logic data_port_rd;
    logic cts_n;
  } usf_uart_state_s;

endpackage

//--- logic/usf_flag_cell.sv
`timescale 1ns/1ps

module usf_flag_cell (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic set_evt, // hardware event
  input wire logic clr_evt, // clear request
  output logic flag // sticky flag
);

  logic flag_reg;
  logic flag_next;

  // set wins over clear so a coincident event is kept
  assign flag_next = set_evt | (flag_reg & ~clr_evt);
  assign flag = flag_reg;

  // sticky storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

endmodule

//--- logic/usf_status.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "usf_regs.svh"

// Operation
// - parity error flag bit 5 sets when a parity-errored character enters rx fifo.
// - parity error flag clears on any software read of serial data port; here a parity-errored character entering that cycle keeps it set.
// - framing error flag bit 4 sets when a framing-errored character enters rx fifo.
// - framing error flag clears on any software read of serial data port; here a framing-errored character entering that cycle keeps it set.
module usf_status (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire usf_pkg::usf_uart_state_s uart_in, // serial unit state
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // ignored
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // ignored
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [`USF_STATUS_WIDTH-1:0] uart_status_word // status word mirror
);

  // word decode, shared by read and write channels
  function automatic usf_pkg::usf_sel_e usf_decode(input logic [31:0] addr);
    usf_pkg::usf_sel_e sel;
    sel = usf_pkg::USF_SEL_NONE;
    if (addr[31:2] == 30'(`USF_STATUS_ADDR >> 2)) begin
      sel = usf_pkg::USF_SEL_STATUS;
    end
    if (addr[31:2] == 30'(`USF_CTRL_ADDR >> 2)) begin
      sel = usf_pkg::USF_SEL_CTRL;
    end
    return sel;
  endfunction

  // sticky error flags
  logic [`USF_NUM_FLAGS-1:0] flag_set;
  logic [`USF_NUM_FLAGS-1:0] flag_clr;
  logic [`USF_NUM_FLAGS-1:0] flag_val;

  // characters entering the rx fifo raise their error flags; an overrun event raises the overrun flag
  assign flag_set[`USF_FLAG_PARITY] = uart_in.rx_char_push & uart_in.rx_char_parity_err;
  assign flag_set[`USF_FLAG_FRAMING] = uart_in.rx_char_push & uart_in.rx_char_frame_err;
  assign flag_set[`USF_FLAG_OVERRUN] = uart_in.rx_overrun_evt;
  // a data port read clears all three; no status write needed
  assign flag_clr[`USF_FLAG_PARITY] = uart_in.data_port_rd;
  assign flag_clr[`USF_FLAG_FRAMING] = uart_in.data_port_rd;
  assign flag_clr[`USF_FLAG_OVERRUN] = uart_in.data_port_rd;

  // one sticky cell per flag
  genvar gi;
  generate
    for (gi = 0; gi < `USF_NUM_FLAGS; gi = gi + 1) begin : g_flag
      usf_flag_cell u_cell (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_evt(flag_set[gi]),
        .clr_evt(flag_clr[gi]),
        .flag(flag_val[gi])
      );
    end
  endgenerate

  // control word: flow enable
  logic flow_en_reg;
  logic flow_en_next;

  // cts reads asserted while flow control is off, as the transmitter sees it
  logic cts_state;
  assign cts_state = flow_en_reg ? ~uart_in.cts_n : 1'b1;

  // assembled status, registered so reads see a clean word
  logic [`USF_STATUS_WIDTH-1:0] status_reg;
  logic [`USF_STATUS_WIDTH-1:0] status_next;

  always_comb begin
    status_next = '0;
    status_next[`USF_BIT_TX_IDLE] = uart_in.tx_fifo_empty & uart_in.tx_ser_idle;
    status_next[`USF_BIT_RX_PARITY] = flag_val[`USF_FLAG_PARITY];
    status_next[`USF_BIT_RX_FRAMING] = flag_val[`USF_FLAG_FRAMING];
    status_next[`USF_BIT_RX_OVERRUN] = flag_val[`USF_FLAG_OVERRUN];
    status_next[`USF_BIT_TX_SPACE] = uart_in.tx_fifo_room;
    status_next[`USF_BIT_RX_VALID] = uart_in.rx_fifo_has_data;
    status_next[`USF_BIT_CTS] = cts_state;
  end

  // status word register; tx idle resets to one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= `USF_STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  assign uart_status_word = status_reg;

  // write channel: address and data accepted in either order
  usf_pkg::usf_wr_state_e wr_state_reg;
  usf_pkg::usf_wr_state_e wr_state_next;
  logic [31:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic aw_fire;
  logic w_fire;
  logic wr_commit;
  logic [31:0] eff_waddr;
  logic [31:0] eff_wdata;
  logic [3:0] eff_wstrb;
  usf_pkg::usf_sel_e wsel;

  // ready while the matching half is still missing
  assign s_axi_awready = (wr_state_reg == usf_pkg::USF_WR_IDLE) |
                         (wr_state_reg == usf_pkg::USF_WR_HAVE_W);
  assign s_axi_wready = (wr_state_reg == usf_pkg::USF_WR_IDLE) |
                        (wr_state_reg == usf_pkg::USF_WR_HAVE_AW);
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;

  // use the half arriving now, else the held one
  assign eff_waddr = aw_fire ? s_axi_awaddr : waddr_reg;
  assign eff_wdata = w_fire ? s_axi_wdata : wdata_reg;
  assign eff_wstrb = w_fire ? s_axi_wstrb : wstrb_reg;
  assign wsel = usf_decode(eff_waddr);

  // next write state
  always_comb begin
    wr_state_next = wr_state_reg;
    case (wr_state_reg)
      usf_pkg::USF_WR_IDLE: begin
        if (aw_fire && w_fire) begin
          wr_state_next = usf_pkg::USF_WR_RESP;
        end else if (aw_fire) begin
          wr_state_next = usf_pkg::USF_WR_HAVE_AW;
        end else if (w_fire) begin
          wr_state_next = usf_pkg::USF_WR_HAVE_W;
        end
      end
      usf_pkg::USF_WR_HAVE_AW: begin
        if (w_fire) begin
          wr_state_next = usf_pkg::USF_WR_RESP;
        end
      end
      usf_pkg::USF_WR_HAVE_W: begin
        if (aw_fire) begin
          wr_state_next = usf_pkg::USF_WR_RESP;
        end
      end
      usf_pkg::USF_WR_RESP: begin
        if (s_axi_bready) begin
          wr_state_next = usf_pkg::USF_WR_IDLE;
        end
      end
      default: begin
        wr_state_next = usf_pkg::USF_WR_IDLE;
      end
    endcase
  end

  // the write takes effect the cycle both halves are in
  assign wr_commit = (wr_state_next == usf_pkg::USF_WR_RESP) &
                     (wr_state_reg != usf_pkg::USF_WR_RESP);

  // status is read only, so a write there is refused with slverr
  assign bresp_next = (wsel == usf_pkg::USF_SEL_CTRL) ? `USF_RESP_OKAY :
                      (wsel == usf_pkg::USF_SEL_STATUS) ? `USF_RESP_SLVERR :
                      `USF_RESP_DECERR;
  assign flow_en_next = (wr_commit && wsel == usf_pkg::USF_SEL_CTRL && eff_wstrb[0]) ?
                        eff_wdata[`USF_BIT_FLOW_EN] : flow_en_reg;

  // write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= usf_pkg::USF_WR_IDLE;
      waddr_reg <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bresp_reg <= `USF_RESP_OKAY;
      flow_en_reg <= `USF_CTRL_RESET;
    end else begin
      wr_state_reg <= wr_state_next;
      waddr_reg <= eff_waddr;
      wdata_reg <= eff_wdata;
      wstrb_reg <= eff_wstrb;
      bresp_reg <= wr_commit ? bresp_next : bresp_reg;
      flow_en_reg <= flow_en_next;
    end
  end

  assign s_axi_bvalid = (wr_state_reg == usf_pkg::USF_WR_RESP);
  assign s_axi_bresp = bresp_reg;

  // read channel: one read in flight, answer one cycle after the address
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic ar_fire;
  usf_pkg::usf_sel_e rsel;
  logic [31:0] rdata_next;
  logic [1:0] rresp_next;

  assign s_axi_arready = ~rvalid_reg;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign rsel = usf_decode(s_axi_araddr);
  // reading status has no side effect; only the data port clears flags
  assign rdata_next = (rsel == usf_pkg::USF_SEL_STATUS) ? {16'h0000, status_reg} :
                      (rsel == usf_pkg::USF_SEL_CTRL) ? {31'h0000_0000, flow_en_reg} :
                      32'h0000_0000;
  assign rresp_next = (rsel == usf_pkg::USF_SEL_NONE) ? `USF_RESP_DECERR : `USF_RESP_OKAY;

  // read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `USF_RESP_OKAY;
    end else begin
      rvalid_reg <= ar_fire | (rvalid_reg & ~s_axi_rready);
      rdata_reg <= ar_fire ? rdata_next : rdata_reg;
      rresp_reg <= ar_fire ? rresp_next : rresp_reg;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule

//--- verif/usf_status_checker.sv
`timescale 1ns/1ps

module usf_status_checker (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire usf_pkg::usf_uart_state_s uart_in, // serial unit state
  input wire logic [15:0] uart_status_word // status mirror
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // shorthands for flagged characters and data port reads
  wire par_evt = uart_in.rx_char_push & uart_in.rx_char_parity_err;
  wire frm_evt = uart_in.rx_char_push & uart_in.rx_char_frame_err;
  wire rd_evt = uart_in.data_port_rd;
  sequence s_par_clr; rd_evt && !par_evt; endsequence
  sequence s_frm_clr; rd_evt && !frm_evt; endsequence
  sequence s_ovf_clr; rd_evt && !uart_in.rx_overrun_evt; endsequence
  property p_par_set; par_evt |-> ##2 uart_status_word[5]; endproperty
  property p_par_clr; s_par_clr |-> ##2 !uart_status_word[5]; endproperty
  property p_frm_set; frm_evt |-> ##2 uart_status_word[4]; endproperty
  property p_frm_clr; s_frm_clr |-> ##2 !uart_status_word[4]; endproperty
  property p_ovf_set; uart_in.rx_overrun_evt |-> ##2 uart_status_word[3]; endproperty
  property p_ovf_clr; s_ovf_clr |-> ##2 !uart_status_word[3]; endproperty
  // level bits lag their inputs by one cycle, once reset is well past
  property p_levels;
    $past(aresetn) && $past(aresetn, 2) |->
      uart_status_word[6] == $past(uart_in.tx_fifo_empty & uart_in.tx_ser_idle) &&
      uart_status_word[2:1] == $past({uart_in.tx_fifo_room, uart_in.rx_fifo_has_data});
  endproperty
  property p_high_zero; uart_status_word[15:7] == 9'h000; endproperty
  a_par_set: assert property (p_par_set) else $error("parity bit not set");
  a_par_clr: assert property (p_par_clr) else $error("parity bit not cleared");
  a_frm_set: assert property (p_frm_set) else $error("framing bit not set");
  a_frm_clr: assert property (p_frm_clr) else $error("framing bit not cleared");
  a_ovf_set: assert property (p_ovf_set) else $error("overrun bit not set");
  a_ovf_clr: assert property (p_ovf_clr) else $error("overrun bit not cleared");
  a_levels: assert property (p_levels) else $error("level bits wrong");
  a_high_zero: assert property (p_high_zero) else $error("upper bits not zero");
endmodule

//--- verif/usf_far_model.sv
`timescale 1ns/1ps

module usf_far_model (
  input wire logic aclk, // system clock
  input wire logic go, // one event request
  input wire logic [1:0] kind, // 0 parity, 1 framing, 2 overrun, 3 data read
  input wire logic [4:0] lv, // empty, ser idle, room, has data, cts_n
  output usf_pkg::usf_uart_state_s st // state to the block
);
  // events leave as one-cycle pulses, registered like the unit's strobes
  always_ff @(posedge aclk) begin
    st <= {lv[4], lv[3], lv[2], lv[1], go && kind < 2'h2, go && kind == 2'h0,
      go && kind == 2'h1, go && kind == 2'h2, go && kind == 2'h3, lv[0]};
  end
endmodule

//--- verif/usf_status_tb.sv
`timescale 1ns/1ps
`include "usf_regs.svh"

module usf_status_tb;
  logic aclk = 0;
  logic aresetn = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, go = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, kind = 0;
  logic [4:0] lv = 5'h1d; // tx idle, room, no rx data, cts_n high
  logic [15:0] sw;
  logic [16:0] seed = 17'h1_71a9;
  usf_pkg::usf_uart_state_s st;
  int err_count = 0, compares = 0, cyc = 0;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  always #4 aclk = ~aclk;
  usf_far_model far (.aclk(aclk), .go(go), .kind(kind), .lv(lv), .st(st));
  usf_status uut (.aclk(aclk), .aresetn(aresetn), .uart_in(st), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .uart_status_word(sw));
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check_r(input [33:0] e, input [33:0] s);
    compares++;
    if (e !== s) begin
      err_count++;
      $display("[ERR] read resp_data exp %h got %h", e, s);
    end
  endtask
  task automatic check_b(input [1:0] e, input [1:0] s);
    compares++;
    if (e !== s) begin
      err_count++;
      $display("[ERR] bresp exp %h got %h", e, s);
    end
  endtask
  // watcher: each answer takes the oldest note; the cycle limit ends a hang
  always @(posedge aclk) begin
    if (rvalid && rready) check_r(exp_r.pop_front(), {rresp, rdata});
    if (bvalid && bready) check_b(exp_b.pop_front(), bresp);
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      end_sim();
    end
  end
  // 17-bit maximal feedback register for the random level patterns
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    lfsr = {s[15:0], s[16] ^ s[13]};
  endfunction
  function automatic [15:0] stat(input [4:0] l, input [2:0] f, input flow);
    stat = {9'h000, l[4] & l[3], f[0], f[1], f[2], l[2], l[1], flow ? ~l[0] : 1'b1};
  endfunction
  // write: address and data offered together, each dropped once taken
  task automatic wr(input [31:0] a, input [31:0] d, input [1:0] r);
    logic aw, w;
    aw = 0;
    w = 0;
    exp_b.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awready && !aw) awvalid <= 0;
      if (wready && !w) wvalid <= 0;
      aw = aw | awready;
      w = w | wready;
    end
    while (!bvalid) @(posedge aclk);
    bready <= 0;
    // one idle edge so the next call never reassigns bready in this step
    @(posedge aclk);
  endtask
  task automatic rd(input [31:0] a, input [33:0] e);
    exp_r.push_back(e);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge aclk);
    rready <= 0;
    // one idle edge so the next call never reassigns rready in this step
    @(posedge aclk);
  endtask
  task automatic ev(input [1:0] k);
    go <= 1;
    kind <= k;
    @(posedge aclk);
    go <= 0;
    repeat (4) @(posedge aclk);
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`USF_STATUS_ADDR, {`USF_RESP_OKAY, 16'h0000, stat(lv, 3'h0, 0)});
    $display("test reset_values done");
    // each sticky error sets alone, survives a status read, clears on data read
    for (int k = 0; k < 3; k++) begin
      ev(k[1:0]);
      rd(`USF_STATUS_ADDR, {`USF_RESP_OKAY, 16'h0000, stat(lv, 3'h1 << k, 0)});
      rd(`USF_STATUS_ADDR, {`USF_RESP_OKAY, 16'h0000, stat(lv, 3'h1 << k, 0)});
      ev(2'h3);
      rd(`USF_STATUS_ADDR, {`USF_RESP_OKAY, 16'h0000, stat(lv, 3'h0, 0)});
    end
    $display("test sticky_flags done");
    wr(`USF_CTRL_ADDR, 32'h0000_0001, `USF_RESP_OKAY);
    // random levels reach every level bit, cts now follows its pin
    repeat (6) begin
      seed = lfsr(seed);
      lv <= seed[4:0];
      repeat (3) @(posedge aclk);
      rd(`USF_STATUS_ADDR, {`USF_RESP_OKAY, 16'h0000, stat(seed[4:0], 3'h0, 1)});
    end
    $display("test level_bits done");
    wr(`USF_STATUS_ADDR, 32'h0000_ffff, `USF_RESP_SLVERR);
    // the refused write must leave the status word as the levels make it
    rd(`USF_STATUS_ADDR, {`USF_RESP_OKAY, 16'h0000, stat(lv, 3'h0, 1)});
    wr(32'h0000_44c8, 32'h0000_0001, `USF_RESP_DECERR);
    rd(32'h0000_44c8, {`USF_RESP_DECERR, 32'h0000_0000});
    // flow enable still set after the refused and unmapped writes
    rd(`USF_CTRL_ADDR, {`USF_RESP_OKAY, 32'h0000_0001});
    $display("test bus_errors done");
    end_sim();
  end
endmodule

bind usf_status usf_status_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .uart_in(uart_in), .uart_status_word(uart_status_word));
